// File: logic/dcw_consts.svh
// Offsets, field positions, reset values and decode constants of the configuration word map
`ifndef DCW_CONSTS_SVH
`define DCW_CONSTS_SVH

// Word indices of the configuration words; the bus byte address is four times the index
`define DCW_OFF_BOOT      24'hf80000
`define DCW_OFF_SPARE     24'hf80002
`define DCW_OFF_GENERAL   24'hf80004
`define DCW_OFF_OSC_SRC   24'hf80006
`define DCW_OFF_OSC       24'hf80008
`define DCW_OFF_WDT       24'hf8000a
`define DCW_OFF_POR       24'hf8000c
`define DCW_OFF_DEBUG     24'hf8000e
`define DCW_OFF_CMP       24'hf80010
// Extra words: load status (bit 0 set once the map is applied) and boot end address
`define DCW_OFF_STATUS    24'hf80014
`define DCW_OFF_BOOT_END  24'hf80018
`define DCW_WORD_BASE     24'hf80000

// Implemented-bit masks; unimplemented bits read as zero unless forced to one
`define DCW_MASK_BOOT     8'h0f
`define DCW_MASK_SPARE    8'h00
`define DCW_MASK_GENERAL  8'h07
`define DCW_MASK_OSC_SRC  8'h87
`define DCW_MASK_OSC      8'hc7
`define DCW_MASK_WDT      8'hff
`define DCW_MASK_POR      8'h67
`define DCW_MASK_DEBUG    8'he3
`define DCW_MASK_CMP      8'h3f
`define DCW_ONES_CMP      8'hc0
`define DCW_ONES_CMP_SMALL 8'hff

// Erased (unprogrammed) value of every nonvolatile byte
`define DCW_ERASED        8'hff

// Boot segment size field
`define DCW_BSS_LSB       1
`define DCW_BSS_MSB       3
`define DCW_BOOT_END_X10  24'h0007fe
`define DCW_BOOT_END_X01  24'h001ffe
`define DCW_BOOT_END_X00  24'h003ffe
`define DCW_BOOT_END_NONE 24'h000000

`endif

// File: logic/dcw_pkg.sv
// Types shared by the configuration word map modules
package dcw_pkg;
    typedef enum logic [3:0] {
        DCW_BOOT, DCW_SPARE, DCW_GENERAL, DCW_OSC_SRC, DCW_OSC,
        DCW_WDT, DCW_POR, DCW_DEBUG, DCW_CMP, DCW_STATUS, DCW_BOOT_END, DCW_NONE
    } dcw_sel_t;

    typedef enum logic [1:0] {
        DCW_ST_RESET, DCW_ST_LOAD, DCW_ST_RUN
    } dcw_state_t;
endpackage

// File: logic/dcw_store_if.sv
// Port bundle between the controller and the configuration byte store
`timescale 1ns/10ps
`default_nettype none
interface dcw_store_if;
    logic       wr_en;
    logic [3:0] wr_idx;
    logic [7:0] wr_data;
    logic [3:0] rd_idx;
    logic [7:0] rd_data;
    modport ctrl  (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
    modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface
`default_nettype wire

// File: logic/dcw_store.sv
// Nonvolatile configuration byte store with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "dcw_consts.svh"
module dcw_store #(
    parameter int DEPTH = 9
) (
    input  wire logic  hclk,
    input  wire logic  hresetn,
    input  wire logic  ce,
    dcw_store_if.store sif
);
    logic [7:0] mem_ff [DEPTH] = '{default: `DCW_ERASED};
    logic [7:0] nxt_mem [DEPTH];
    logic [7:0] rd_ff;
    logic [7:0] nxt_rd;

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            nxt_mem[i] = mem_ff[i];
        end
        if (sif.wr_en && (int'(sif.wr_idx) < DEPTH)) begin
            nxt_mem[sif.wr_idx] = sif.wr_data;
        end
        nxt_rd = (int'(sif.rd_idx) < DEPTH) ? mem_ff[sif.rd_idx] : 8'h00;
    end

    // Nonvolatile: bytes survive hresetn, else nothing written could ever be applied;
    // the declaration stands in for erased flash at power-up
    always_ff @(posedge hclk) begin
        if (ce) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= nxt_mem[i];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ff <= 8'h00;
        end else if (ce) begin
            rd_ff <= nxt_rd;
        end
    end

    assign sif.rd_data = rd_ff;
endmodule
`default_nettype wire

// File: logic/dcw_boot_decode.sv
// Boot segment size to boot segment end address decoder
`timescale 1ns/10ps
`default_nettype none
`include "dcw_consts.svh"
module dcw_boot_decode (
    input  wire logic [2:0]  bss,
    output logic      [23:0] boot_end,
    output logic             boot_en
);
    // The top bit of the size field is a don't care
    always_comb begin
        unique case (bss[1:0])
            2'h2: begin
                boot_end = `DCW_BOOT_END_X10;
                boot_en  = 1'b1;
            end
            2'h1: begin
                boot_end = `DCW_BOOT_END_X01;
                boot_en  = 1'b1;
            end
            2'h0: begin
                boot_end = `DCW_BOOT_END_X00;
                boot_en  = 1'b1;
            end
            2'h3: begin
                boot_end = `DCW_BOOT_END_NONE;
                boot_en  = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// File: logic/dcw_top.sv
// Configuration word map: AHB-Lite access, reset-time latch and field decode
`timescale 1ns/10ps
`default_nettype none
`include "dcw_consts.svh"
module dcw_top #(
    parameter bit SMALL_VARIANT = 1'b0,
    parameter int NUM_CFG       = 9
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [23:0] boot_end_addr,
    output logic             boot_seg_en,
    output logic             boot_write_protect,
    output logic      [7:0]  wdt_cfg,
    output logic      [7:0]  cmp_cfg,
    output logic             cfg_valid
);
    // ======================================================================
    // Address decode
    // ======================================================================
    function automatic dcw_pkg::dcw_sel_t dcw_decode(input logic [31:0] a);
        unique case (a[25:2])
            `DCW_OFF_BOOT:     dcw_decode = dcw_pkg::DCW_BOOT;
            `DCW_OFF_SPARE:    dcw_decode = dcw_pkg::DCW_SPARE;
            `DCW_OFF_GENERAL:  dcw_decode = dcw_pkg::DCW_GENERAL;
            `DCW_OFF_OSC_SRC:  dcw_decode = dcw_pkg::DCW_OSC_SRC;
            `DCW_OFF_OSC:      dcw_decode = dcw_pkg::DCW_OSC;
            `DCW_OFF_WDT:      dcw_decode = dcw_pkg::DCW_WDT;
            `DCW_OFF_POR:      dcw_decode = dcw_pkg::DCW_POR;
            `DCW_OFF_DEBUG:    dcw_decode = dcw_pkg::DCW_DEBUG;
            `DCW_OFF_CMP:      dcw_decode = dcw_pkg::DCW_CMP;
            `DCW_OFF_STATUS:   dcw_decode = dcw_pkg::DCW_STATUS;
            `DCW_OFF_BOOT_END: dcw_decode = dcw_pkg::DCW_BOOT_END;
            default:           dcw_decode = dcw_pkg::DCW_NONE;
        endcase
    endfunction

    // Read view of a byte: mask unimplemented bits, force the read-as-one bits
    function automatic logic [7:0] dcw_view(input logic [3:0] idx, input logic [7:0] v);
        logic [7:0] m;
        logic [7:0] ones;
        m    = 8'h00;
        ones = 8'h00;
        unique case (idx)
            4'h0: m = `DCW_MASK_BOOT;
            4'h1: m = `DCW_MASK_SPARE;
            4'h2: m = `DCW_MASK_GENERAL;
            4'h3: m = `DCW_MASK_OSC_SRC;
            4'h4: m = `DCW_MASK_OSC;
            4'h5: m = `DCW_MASK_WDT;
            4'h6: m = `DCW_MASK_POR;
            4'h7: m = `DCW_MASK_DEBUG;
            4'h8: begin
                m    = `DCW_MASK_CMP;
                ones = SMALL_VARIANT ? `DCW_ONES_CMP_SMALL : `DCW_ONES_CMP;
            end
            default: m = 8'h00;
        endcase
        dcw_view = (v & m) | ones;
    endfunction

    // ======================================================================
    // Bus slave: address phase capture
    // ======================================================================
    logic                  act_ff;
    logic                  nxt_act;
    logic                  wr_ff;
    logic                  nxt_wr;
    dcw_pkg::dcw_sel_t     sel_ff;
    dcw_pkg::dcw_sel_t     nxt_sel;
    logic [31:0]           hrdata_ff;
    logic [31:0]           nxt_hrdata;
    logic                  rd_pend_ff;
    logic                  nxt_rd_pend;

    dcw_store_if sif ();

    dcw_store #(
        .DEPTH (NUM_CFG)
    ) u_store (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .sif     (sif)
    );

    logic take;
    assign take = hsel && hready && htrans[1];

    // ======================================================================
    // Latch controller
    // ======================================================================
    dcw_pkg::dcw_state_t   st_ff;
    dcw_pkg::dcw_state_t   nxt_st;
    logic [3:0]            ld_idx_ff;
    logic [3:0]            nxt_ld_idx;
    logic [7:0]            lat_ff [NUM_CFG];
    logic [7:0]            nxt_lat [NUM_CFG];

    // Store reads are one cycle late, so the loader reads index i and writes i-1
    always_comb begin
        nxt_st     = st_ff;
        nxt_ld_idx = ld_idx_ff;
        for (int i = 0; i < NUM_CFG; i++) begin
            nxt_lat[i] = lat_ff[i];
        end
        unique case (st_ff)
            dcw_pkg::DCW_ST_RESET: begin
                nxt_st     = dcw_pkg::DCW_ST_LOAD;
                nxt_ld_idx = 4'h1;
            end
            dcw_pkg::DCW_ST_LOAD: begin
                nxt_lat[ld_idx_ff - 4'h1] = sif.rd_data;
                if (int'(ld_idx_ff) == NUM_CFG) begin
                    nxt_st = dcw_pkg::DCW_ST_RUN;
                end else begin
                    nxt_ld_idx = ld_idx_ff + 4'h1;
                end
            end
            dcw_pkg::DCW_ST_RUN: begin
                nxt_st = dcw_pkg::DCW_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff     <= dcw_pkg::DCW_ST_RESET;
            ld_idx_ff <= 4'h0;
            for (int i = 0; i < NUM_CFG; i++) begin
                lat_ff[i] <= 8'h00;
            end
        end else if (ce) begin
            st_ff     <= nxt_st;
            ld_idx_ff <= nxt_ld_idx;
            for (int i = 0; i < NUM_CFG; i++) begin
                lat_ff[i] <= nxt_lat[i];
            end
        end
    end

    // ======================================================================
    // Store port sharing and bus data phase
    // ======================================================================
    logic loading;
    assign loading = (st_ff != dcw_pkg::DCW_ST_RUN);

    // Writes land in the store only; the applied map changes at next reset
    assign sif.wr_en   = act_ff && wr_ff && (int'(sel_ff) < NUM_CFG) && ce;
    assign sif.wr_idx  = 4'(int'(sel_ff));
    assign sif.wr_data = hwdata[7:0];
    assign sif.rd_idx  = loading ? ld_idx_ff - (st_ff == dcw_pkg::DCW_ST_RESET ? 4'h0 : 4'h0)
                                 : (take ? 4'(int'(dcw_decode(haddr))) : 4'h0);

    logic [23:0] bend;
    logic        ben;
    dcw_boot_decode u_dec (
        .bss      (lat_ff[0][`DCW_BSS_MSB:`DCW_BSS_LSB]),
        .boot_end (bend),
        .boot_en  (ben)
    );

    logic [7:0] status_b;
    assign status_b = {7'h00, ~loading};

    always_comb begin
        nxt_act     = take && !loading;
        nxt_wr      = hwrite;
        nxt_sel     = dcw_decode(haddr);
        nxt_rd_pend = act_ff && !wr_ff;
        nxt_hrdata  = hrdata_ff;
        if (!take || loading) begin
            nxt_wr  = wr_ff;
            nxt_sel = sel_ff;
        end
        // Loaded in the wait state, so the word stands while hreadyout is high
        if (act_ff && !wr_ff) begin
            if (int'(sel_ff) < NUM_CFG) begin
                nxt_hrdata = {24'h0, dcw_view(4'(int'(sel_ff)), sif.rd_data)};
            end else if (sel_ff == dcw_pkg::DCW_STATUS) begin
                nxt_hrdata = {24'h0, status_b};
            end else if (sel_ff == dcw_pkg::DCW_BOOT_END) begin
                nxt_hrdata = {8'h0, bend};
            end else begin
                nxt_hrdata = 32'h0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_ff     <= 1'b0;
            wr_ff      <= 1'b0;
            sel_ff     <= dcw_pkg::DCW_NONE;
            hrdata_ff  <= 32'h0;
            rd_pend_ff <= 1'b0;
        end else if (ce) begin
            act_ff     <= nxt_act;
            wr_ff      <= nxt_wr;
            sel_ff     <= nxt_sel;
            hrdata_ff  <= nxt_hrdata;
            rd_pend_ff <= nxt_rd_pend;
        end
    end

    // Reads need a second cycle for the registered store output; writes
    // finish at once, and nothing is taken while the map loads
    always_comb begin
        hreadyout = 1'b1;
        if (loading) begin
            hreadyout = 1'b0;
        end else if (act_ff && !wr_ff && !rd_pend_ff) begin
            hreadyout = 1'b0;
        end
    end
    assign hrdata    = hrdata_ff;
    assign hresp     = 1'b0;

    // ======================================================================
    // Applied settings
    // ======================================================================
    assign boot_end_addr      = bend;
    assign boot_seg_en        = ben;
    assign boot_write_protect = lat_ff[0][0];
    assign wdt_cfg            = lat_ff[5];
    assign cmp_cfg            = dcw_view(4'h8, lat_ff[8]);
    assign cfg_valid          = !loading;

    // ======================================================================
    // Checks
    // ======================================================================
    boot_end_x10_a : assert property (@(posedge hclk) disable iff (!hresetn)
        (lat_ff[0][2:1] == 2'h2) |-> (boot_end_addr == 24'h0007fe))
        else $error("boot end wrong for x10");
    boot_end_x01_a : assert property (@(posedge hclk) disable iff (!hresetn)
        (lat_ff[0][2:1] == 2'h1) |-> (boot_end_addr == 24'h001ffe))
        else $error("boot end wrong for x01");
    boot_end_x00_a : assert property (@(posedge hclk) disable iff (!hresetn)
        (lat_ff[0][2:1] == 2'h0) |-> (boot_end_addr == 24'h003ffe))
        else $error("boot end wrong for x00");
    unimpl_zero_a : assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_pend_ff && sel_ff == dcw_pkg::DCW_BOOT) |-> (hrdata[7:4] == 4'h0))
        else $error("unimplemented bits not zero");
    cmp_top_ones_a : assert property (@(posedge hclk) disable iff (!hresetn)
        cfg_valid |-> (cmp_cfg[7:6] == 2'h3))
        else $error("comparator top bits not one");
    cmp_small_a : assert property (@(posedge hclk) disable iff (!hresetn)
        (SMALL_VARIANT && cfg_valid) |-> (cmp_cfg == 8'hff))
        else $error("small variant comparator not all ones");
    cfg_hold_a : assert property (@(posedge hclk) disable iff (!hresetn)
        (cfg_valid && ce) |=> (cfg_valid && $stable(wdt_cfg) && $stable(boot_end_addr)))
        else $error("applied configuration changed");
    load_time_a : assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff == dcw_pkg::DCW_ST_RESET && ce) |=> loading [*1] ##[0:20] cfg_valid)
        else $error("configuration load too slow");
    spare_zero_a : assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_pend_ff && sel_ff == dcw_pkg::DCW_SPARE) |-> (hrdata == 32'h0))
        else $error("spare word not zero");
    byte_upper_a : assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_pend_ff && int'(sel_ff) < NUM_CFG) |-> (hrdata[31:8] == 24'h0))
        else $error("upper read bits not zero");
    cmp_read_ones_a : assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_pend_ff && sel_ff == dcw_pkg::DCW_CMP) |-> (hrdata[7:6] == 2'h3))
        else $error("comparator read top bits not one");
    load_busy_a : assert property (@(posedge hclk) disable iff (!hresetn)
        loading |-> !hreadyout)
        else $error("bus ready while loading");
    ce_freeze_a : assert property (@(posedge hclk) disable iff (!hresetn)
        !ce |=> ($stable(st_ff) && $stable(hrdata) && $stable(wdt_cfg)))
        else $error("state moved while clock enable low");

    // Bus timing and decode choices
    read_wait_a : assert property (@(posedge hclk) disable iff (!hresetn)
        (act_ff && !wr_ff && !rd_pend_ff) |-> !hreadyout)
        else $error("read answered without wait state");
    write_no_wait_a : assert property (@(posedge hclk) disable iff (!hresetn)
        (act_ff && wr_ff && !loading) |-> hreadyout)
        else $error("write answered late");
    boot_none_a : assert property (@(posedge hclk) disable iff (!hresetn)
        (cfg_valid && lat_ff[0][2:1] == 2'h3) |-> (!boot_seg_en && boot_end_addr == 24'h0))
        else $error("boot segment shown for size x11");
endmodule
`default_nettype wire

// File: testbench/dcw_top_tb_top.sv
// Self-checking bench for the configuration word map over AHB-Lite
`timescale 1ns/10ps
`default_nettype none
`include "dcw_consts.svh"
module dcw_top_tb_top;
    // ==========================================================
    // Signals
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        ce      = 1'b1;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hwdata  = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] hrdata_s;
    logic        hreadyout;
    logic        hresp;
    logic [23:0] boot_end_addr;
    logic        boot_seg_en;
    logic        boot_write_protect;
    logic [7:0]  wdt_cfg;
    logic [7:0]  cmp_cfg;
    logic [7:0]  cmp_cfg_s;
    logic        cfg_valid;
    int          err_total  = 0;
    int          num_checks = 0;
    logic [31:0] rd;
    logic [31:0] rd_s;
    logic [31:0] rnd;
    logic [7:0]  mem [9];
    logic [7:0]  rb;
    logic [7:0]  rw;

    localparam logic [23:0] OFFS [9] = '{`DCW_OFF_BOOT, `DCW_OFF_SPARE, `DCW_OFF_GENERAL,
        `DCW_OFF_OSC_SRC, `DCW_OFF_OSC, `DCW_OFF_WDT, `DCW_OFF_POR, `DCW_OFF_DEBUG, `DCW_OFF_CMP};
    localparam logic [7:0] MASK [9] = '{`DCW_MASK_BOOT, `DCW_MASK_SPARE, `DCW_MASK_GENERAL,
        `DCW_MASK_OSC_SRC, `DCW_MASK_OSC, `DCW_MASK_WDT, `DCW_MASK_POR, `DCW_MASK_DEBUG,
        `DCW_MASK_CMP};
    localparam logic [2:0] BSS_PAT [7] = '{3'h2, 3'h1, 3'h0, 3'h6, 3'h5, 3'h4, 3'h3};

    // ==========================================================
    // Devices: full-pin variant checked in depth, small variant for its comparator byte
    dcw_top #(.SMALL_VARIANT(1'b0), .NUM_CFG(9)) i_dut (.hclk(hclk), .hresetn(hresetn),
        .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .boot_end_addr(boot_end_addr), .boot_seg_en(boot_seg_en),
        .boot_write_protect(boot_write_protect), .wdt_cfg(wdt_cfg), .cmp_cfg(cmp_cfg),
        .cfg_valid(cfg_valid));
    // Shares the bus of the first device; same latency, so it follows its hready
    dcw_top #(.SMALL_VARIANT(1'b1), .NUM_CFG(9)) i_dut_small (.hclk(hclk),
        .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata_s), .hreadyout(), .hresp(), .boot_end_addr(), .boot_seg_en(),
        .boot_write_protect(), .wdt_cfg(), .cmp_cfg(cmp_cfg_s), .cfg_valid());

    always #12.5 hclk = ~hclk;

    // ==========================================================
    // Expectations and checks
    function automatic logic [7:0] exp_rd(input int i, input logic [7:0] v);
        return (i == 8) ? ((v & MASK[8]) | 8'hc0) : (v & MASK[i]);
    endfunction

    function automatic logic [23:0] boot_end(input logic [2:0] s);
        case (s[1:0])
            2'b10: return 24'h0007fe;
            2'b01: return 24'h001ffe;
            2'b00: return 24'h003ffe;
            default: return 24'h000000;
        endcase
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Single word transfer; waits on hready in both phases, the watchdog bounds it
    task automatic xfer(input logic wr, input logic [23:0] off, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {6'h00, off, 2'b00};
        hwrite <= wr;
        hsize  <= 3'h2;
        do begin @(posedge hclk); end while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        do begin @(posedge hclk); end while (hreadyout !== 1'b1);
        rd   = hrdata;
        rd_s = hrdata_s;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic do_reset();
        int n;
        hresetn <= 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        n = 0;
        while (cfg_valid !== 1'b1 && n < 200) begin @(posedge hclk); n++; end
        chk("cfg_valid", 32'h1, {31'h0, cfg_valid});
        xfer(1'b0, `DCW_OFF_STATUS, 32'h0);
        chk("status", 32'h1, rd & 32'h1);
    endtask

    // Applied outputs must follow the bytes latched at the last reset
    task automatic chk_applied(input logic [7:0] b, input logic [7:0] w, input logic [7:0] c);
        chk("boot_end_addr", {8'h0, boot_end(b[3:1])}, {8'h0, boot_end_addr});
        chk("boot_seg_en", {31'h0, b[2:1] != 2'b11}, {31'h0, boot_seg_en});
        chk("boot_write_protect", {31'h0, b[0]}, {31'h0, boot_write_protect});
        chk("wdt_cfg", {24'h0, w}, {24'h0, wdt_cfg});
        chk("cmp_cfg", {24'h0, 2'b11, c[5:0]}, {24'h0, cmp_cfg});
        chk("cmp_cfg small", 32'hff, {24'h0, cmp_cfg_s});
    endtask

    task automatic results();
        $display("Checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(96882));
        do_reset();
        // Erased map: unimplemented bits read zero, comparator top bits read one
        for (int i = 0; i < 9; i++) begin
            xfer(1'b0, OFFS[i], 32'h0);
            chk("erased word", {24'h0, exp_rd(i, 8'hff)}, rd);
        end
        chk("cmp small word", 32'hff, rd_s);
        // Clock enable low: applied map and bus state must sit still
        ce <= 1'b0;
        repeat (4) @(posedge hclk);
        chk("cfg_valid ce low", 32'h1, {31'h0, cfg_valid});
        ce <= 1'b1;
        xfer(1'b0, 24'hf8001c, 32'h0);
        chk("unmapped word", 32'h0, rd);
        chk_applied(8'hff, 8'hff, 8'hff);
        // Random writes, an idle address phase between each; reserved tool bits kept at one as programmers must
        for (int i = 0; i < 9; i++) begin
            rnd    = $urandom;
            mem[i] = rnd[7:0];
            if (i == 5) mem[i][5] = 1'b1;
            if (i == 7) mem[i][7:6] = 2'b11;
            xfer(1'b1, OFFS[i], {rnd[31:8], mem[i]});
        end
        for (int i = 0; i < 9; i++) begin
            xfer(1'b0, OFFS[i], 32'h0);
            chk("written word", {24'h0, exp_rd(i, mem[i])}, rd);
            if (i == 8) chk("cmp small written", 32'hff, rd_s);
        end
        chk_applied(8'hff, 8'hff, 8'hff);
        xfer(1'b0, `DCW_OFF_BOOT_END, 32'h0);
        chk("boot end word", 32'h0, rd);
        // Every size pattern but 3'h7, applied only through a fresh reset
        rb = 8'hff;
        for (int k = 0; k < 7; k++) begin
            rnd = $urandom;
            xfer(1'b1, `DCW_OFF_BOOT, {24'h0, rnd[7:4], BSS_PAT[k], rnd[0]});
            xfer(1'b1, `DCW_OFF_WDT, {24'h0, rnd[15:8] | 8'h20});
            chk("boot_end held", {8'h0, boot_end(rb[3:1])}, {8'h0, boot_end_addr});
            rb = {rnd[7:4], BSS_PAT[k], rnd[0]};
            rw = rnd[15:8] | 8'h20;
            do_reset();
            xfer(1'b0, `DCW_OFF_BOOT, 32'h0);
            chk("boot word", {24'h0, exp_rd(0, rb)}, rd);
            xfer(1'b0, `DCW_OFF_WDT, 32'h0);
            chk("wdt word", {24'h0, exp_rd(5, rw)}, rd);
            xfer(1'b0, `DCW_OFF_CMP, 32'h0);
            chk("cmp word", {24'h0, exp_rd(8, mem[8])}, rd);
            chk_applied(rb, rw, mem[8]);
            xfer(1'b0, `DCW_OFF_BOOT_END, 32'h0);
            chk("boot end word", {8'h0, boot_end(rb[3:1])}, rd);
        end
        results();
    end

    // Whole run is well under a few thousand cycles
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        $display("Error watchdog expected finish seen timeout");
        results();
    end
endmodule
`default_nettype wire
